// ==== rtl/tcp_chan.v ====
// one capture/compare channel: edge detect, compare match and pin drive
`timescale 1ns/1ps
`include "tcp_consts.vh"
module tcp_chan #(
    parameter WIDTH = 16
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // counter
    input wire tick,
    input wire wrap,
    input wire [WIDTH-1:0] cnt_nxt,
    // effective control
    input wire ocmode,
    input wire [1:0] els,
    input wire tov,
    input wire maxd,
    input wire [WIDTH-1:0] cmpv,
    // pin
    input wire pin_s,
    output reg pin_q,
    // events
    output wire cap_ev,
    output wire cmp_ev
);
    reg prev_q;
    wire rise;
    wire fall;
    wire ovf_tog;
    reg p1;

    assign rise = pin_s & ~prev_q;
    assign fall = ~pin_s & prev_q;
    assign cap_ev = ~ocmode & ((els[0] & rise) | (els[1] & fall));
    // width equals value
    // match when the counter steps onto the value: width from overflow = value
    assign cmp_ev = ocmode & tick & (cnt_nxt == cmpv);
    assign ovf_tog = ocmode & wrap & tov;

    // pin state after an overflow toggle, before the compare action
    always @* begin
        p1 = ovf_tog ? ~pin_q : pin_q;
    end

    // pin drive; compare action applies after a same-tick overflow toggle
    always @(posedge clk) begin
        if (!resetn) begin
            prev_q <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            prev_q <= pin_s;
            if (ocmode && maxd && !tov) begin
                pin_q <= 1'b1;
            end else if (cmp_ev) begin
                case (els)
                    `TCP_ELS_TOG: pin_q <= ~p1;
                    `TCP_ELS_CLR: pin_q <= 1'b0;
                    `TCP_ELS_SET: pin_q <= 1'b1;
                    default: pin_q <= p1;
                endcase
            end else begin
                pin_q <= p1;
            end
        end
    end
endmodule // tcp_chan

// ==== rtl/tcp_consts.vh ====
// register map, field positions and reset values of the capture/compare timer
`ifndef TCP_CONSTS_VH
`define TCP_CONSTS_VH
// word indexes (byte address = index * 4)
`define TCP_IX_SC 6'h00
`define TCP_IX_CNT 6'h01
`define TCP_IX_MOD 6'h02
`define TCP_IX_CH0 6'h04
`define TCP_IX_END 6'h0C
// timer status and control fields
`define TCP_SC_TOF 7
`define TCP_SC_OVERFLOW_IRQ_ENABLE 6
`define TCP_SC_TSTOP 5
`define TCP_SC_TRST 4
// channel control fields
`define TCP_CH_FLAG 7
`define TCP_CH_IE 6
`define TCP_CH_MSB 5
`define TCP_CH_MSA 4
`define TCP_CH_ELSB 3
`define TCP_CH_ELSA 2
`define TCP_CH_TOV 1
`define TCP_CH_MAX 0
// edge/level select actions in compare mode
`define TCP_ELS_OFF 2'h0
`define TCP_ELS_TOG 2'h1
`define TCP_ELS_CLR 2'h2
`define TCP_ELS_SET 2'h3
// reset values, and the prescaler code that picks the external clock
`define TCP_MOD_RST 16'hFFFF
`define TCP_PS_RST 3'h0
`define TCP_PS_EXT 3'h7
// bus responses
`define TCP_RESP_OK 2'h0
`define TCP_RESP_ERR 2'h2
`endif

// ==== rtl/tcp_count.v ====
// prescaler and free-running modulo counter
`timescale 1ns/1ps
`include "tcp_consts.vh"
module tcp_count #(
    parameter WIDTH = 16
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // control
    input wire [2:0] ps,
    input wire stop,
    input wire clr,
    input wire [WIDTH-1:0] modulo,
    input wire ext_clk_s,
    // state
    output reg [WIDTH-1:0] cnt_q,
    output wire [WIDTH-1:0] cnt_nxt,
    output wire tick,
    output wire wrap
);
    reg [6:0] div_q;
    reg ext_prev_q;
    wire [6:0] msk;
    wire pre_tick;

    // divide by 2^ps; ps of seven picks the external clock edge
    assign msk = ~(7'h7F << ps);
    assign pre_tick = (ps == `TCP_PS_EXT) ? (ext_clk_s & ~ext_prev_q) :
                      ((div_q & msk) == msk);
    assign tick = pre_tick & ~stop;
    assign wrap = tick & (cnt_q == modulo);
    assign cnt_nxt = wrap ? {WIDTH{1'b0}} : cnt_q + 1'b1;

    // divider and counter; a stopped timer keeps its phase
    always @(posedge clk) begin
        if (!resetn) begin
            div_q <= 7'h00;
            ext_prev_q <= 1'b0;
            cnt_q <= {WIDTH{1'b0}};
        end else begin
            ext_prev_q <= ext_clk_s;
            if (clr) begin
                div_q <= 7'h00;
                cnt_q <= {WIDTH{1'b0}};
            end else begin
                if (!stop)
                    div_q <= div_q + 7'h01;
                if (tick)
                    cnt_q <= cnt_nxt;
            end
        end
    end
endmodule // tcp_count

// ==== rtl/tcp_top.v ====
// four-channel 16-bit timer capture/compare/pwm with an AXI4-Lite slave
//
// Contract
// - active capture edge copies the counter into the channel value.
// - software picks rising, falling or both edges per capture channel.
// - an enabled capture raises the interrupt request.
// - compare match sets, clears or toggles the pin as configured.
// - an enabled compare match raises the interrupt request.
// - unbuffered value writes replace the compare value at once.
// - link bit in channel 0 joins channels 0 and 1 on pin 0.
// - linked pair takes its compare value from the last written channel at overflow.
// - channel 0 control governs the linked pair; channel 1 ignored.
// - linked channel 1 pin is released.
// - link bit in channel 2 joins channels 2 and 3 likewise.
// - toggle-on-overflow toggles the pin at the modulo wrap.
// - PWM period is modulo plus one counter clocks.
// - pulse width equals compare value counter clocks after overflow.
// - compare event ends the pulse; overflow event ends the period.
// - counter wraps to zero after modulo, setting the overflow flag.
// - mode 01 unbuffered, 10 buffered; select 10 clears, 11 sets.
// - no overflow toggle gives 0% duty; max bit then gives 100%.
`timescale 1ns/1ps
`include "tcp_consts.vh"
module tcp_top #(
    parameter WIDTH = 16
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // external timer clock pin
    input wire ext_clk_pin,
    // channel pins
    input wire chan0_pin_in,
    output wire chan0_pin_out,
    output wire chan0_pin_oe,
    input wire chan1_pin_in,
    output wire chan1_pin_out,
    output wire chan1_pin_oe,
    input wire chan2_pin_in,
    output wire chan2_pin_out,
    output wire chan2_pin_oe,
    input wire chan3_pin_in,
    output wire chan3_pin_out,
    output wire chan3_pin_oe,
    // interrupt request
    output wire irq
);
    // bus state
    reg awready_q;
    reg wready_q;
    reg aw_full_q;
    reg w_full_q;
    reg [7:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg arready_q;
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;
    // timer registers
    reg overflow_flag_q;
    reg overflow_irq_enable_q;
    reg tstop_q;
    reg [2:0] ps_q;
    reg [WIDTH-1:0] mod_q;
    reg [3:0] channel_event_flag_q;
    reg [3:0] channel_irq_enable_q;
    reg [3:0] msb_q;
    reg [3:0] msa_q;
    reg [7:0] edge_level_select_q;
    reg [3:0] toggle_on_overflow_q;
    reg [3:0] max_duty_bit_q;
    reg [WIDTH-1:0] val_q [0:3];
    reg [1:0] act_q;
    reg [1:0] last_q;
    reg [3:0] oe_q;
    reg irq_q;
    reg [4:0] sync1_q;
    reg [4:0] sync2_q;
    // internal wires
    wire [WIDTH-1:0] cnt_q;
    wire [WIDTH-1:0] cnt_nxt;
    wire tick;
    wire wrap;
    wire wr_do;
    wire [5:0] widx;
    wire [5:0] wsub;
    wire wch_hit;
    wire [5:0] ridx;
    wire [5:0] rsub;
    wire [3:0] wr_ctl;
    wire [3:0] wr_val;
    wire [3:0] cap;
    wire [3:0] cmpe;
    wire [3:0] pin_q;
    wire [3:0] linked;
    wire [3:0] ocm;
    wire [WIDTH-1:0] cmpv [0:3];
    wire [WIDTH-1:0] vmerge;
    wire trst;
    wire ovf_clr;
    reg [31:0] rd_mux;
    reg rd_err;
    integer i;

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign irq = irq_q;
    assign {chan3_pin_out, chan2_pin_out, chan1_pin_out, chan0_pin_out} = pin_q;
    assign {chan3_pin_oe, chan2_pin_oe, chan1_pin_oe, chan0_pin_oe} = oe_q;

    // two-flop synchronisers for all pins read by the timer
    always @(posedge clk) begin
        if (!resetn) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else begin
            sync1_q <= {ext_clk_pin, chan3_pin_in, chan2_pin_in,
                        chan1_pin_in, chan0_pin_in};
            sync2_q <= sync1_q;
        end
    end

    // write decode; address and data may arrive in either order
    assign wr_do = aw_full_q & w_full_q & ~bvalid_q;
    assign widx = aw_addr_q[7:2];
    assign wsub = widx - `TCP_IX_CH0;
    assign wch_hit = (widx >= `TCP_IX_CH0) && (widx < `TCP_IX_END);
    assign trst = wr_do && (widx == `TCP_IX_SC) && w_strb_q[0] && w_data_q[`TCP_SC_TRST];
    assign ovf_clr = wr_do && (widx == `TCP_IX_SC) && w_strb_q[0] && !w_data_q[`TCP_SC_TOF];
    assign vmerge = {w_strb_q[1] ? w_data_q[15:8] : val_q[wsub[2:1]][15:8],
                     w_strb_q[0] ? w_data_q[7:0] : val_q[wsub[2:1]][7:0]};

    // axi4-lite handshakes; ready drops once an item is held
    always @(posedge clk) begin
        if (!resetn) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `TCP_RESP_OK;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `TCP_RESP_OK;
        end else begin
            awready_q <= ~aw_full_q & ~(s_axi_awvalid & awready_q) & ~wr_do;
            wready_q <= ~w_full_q & ~(s_axi_wvalid & wready_q) & ~wr_do;
            if (s_axi_awvalid && awready_q) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (widx < `TCP_IX_END && widx != 6'h03) ?
                           `TCP_RESP_OK : `TCP_RESP_ERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            arready_q <= ~rvalid_q & ~(s_axi_arvalid & arready_q);
            if (s_axi_arvalid && arready_q) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= rd_err ? `TCP_RESP_ERR : `TCP_RESP_OK;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // read mux; reserved bits read zero
    assign ridx = s_axi_araddr[7:2];
    assign rsub = ridx - `TCP_IX_CH0;
    always @* begin
        rd_mux = 32'h00000000;
        rd_err = 1'b0;
        case (ridx)
            `TCP_IX_SC: rd_mux[7:0] = {overflow_flag_q, overflow_irq_enable_q,
                                     tstop_q, 2'h0, ps_q};
            `TCP_IX_CNT: rd_mux[15:0] = cnt_q;
            `TCP_IX_MOD: rd_mux[15:0] = mod_q;
            default: begin
                if (ridx >= `TCP_IX_CH0 && ridx < `TCP_IX_END) begin
                    // pair reported in the even control
                    if (ridx[0])
                        rd_mux[15:0] = val_q[rsub[2:1]];
                    else
                        rd_mux[7:0] = {channel_event_flag_q[rsub[2:1]],
                                       channel_irq_enable_q[rsub[2:1]],
                                       msb_q[rsub[2:1]], msa_q[rsub[2:1]],
                                       edge_level_select_q[2*rsub[2:1] +: 2],
                                       toggle_on_overflow_q[rsub[2:1]],
                                       max_duty_bit_q[rsub[2:1]]};
                end else begin
                    rd_err = 1'b1;
                end
            end
        endcase
    end

    // per-channel write strobes and effective modes
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ch
            assign wr_ctl[g] = wr_do & wch_hit & ~widx[0] & (wsub[2:1] == g);
            assign wr_val[g] = wr_do & wch_hit & widx[0] & (wsub[2:1] == g);
            if (g % 2 == 1) begin : g_odd
                assign linked[g] = msb_q[g-1];
                assign cmpv[g] = val_q[g];
            end else begin : g_even
                assign linked[g] = 1'b0;
                assign cmpv[g] = (msb_q[g] & act_q[g/2]) ? val_q[g+1] : val_q[g];
            end
            assign ocm[g] = ~linked[g] & (msb_q[g] | msa_q[g]);
            tcp_chan #(.WIDTH(WIDTH)) u_chan (
                .clk(clk),
                .resetn(resetn),
                .tick(tick),
                .wrap(wrap),
                .cnt_nxt(cnt_nxt),
                .ocmode(ocm[g]),
                .els(linked[g] ? `TCP_ELS_OFF : edge_level_select_q[2*g +: 2]),
                .tov(toggle_on_overflow_q[g]),
                .maxd(max_duty_bit_q[g]),
                .cmpv(cmpv[g]),
                .pin_s(sync2_q[g]),
                .pin_q(pin_q[g]),
                .cap_ev(cap[g]),
                .cmp_ev(cmpe[g])
            );
        end
    endgenerate

    tcp_count #(.WIDTH(WIDTH)) u_count (
        .clk(clk),
        .resetn(resetn),
        .ps(ps_q),
        .stop(tstop_q),
        .clr(trst),
        .modulo(mod_q),
        .ext_clk_s(sync2_q[4]),
        .cnt_q(cnt_q),
        .cnt_nxt(cnt_nxt),
        .tick(tick),
        .wrap(wrap)
    );

    // timer and channel registers; hardware set wins over software clear
    always @(posedge clk) begin
        if (!resetn) begin
            overflow_flag_q <= 1'b0;
            overflow_irq_enable_q <= 1'b0;
            tstop_q <= 1'b0;
            ps_q <= `TCP_PS_RST;
            mod_q <= `TCP_MOD_RST;
            channel_event_flag_q <= 4'h0;
            channel_irq_enable_q <= 4'h0;
            msb_q <= 4'h0;
            msa_q <= 4'h0;
            edge_level_select_q <= 8'h00;
            toggle_on_overflow_q <= 4'h0;
            max_duty_bit_q <= 4'h0;
            for (i = 0; i < 4; i = i + 1)
                val_q[i] <= {WIDTH{1'b0}};
        end else begin
            overflow_flag_q <= wrap | (overflow_flag_q & ~ovf_clr);
            if (wr_do && widx == `TCP_IX_SC && w_strb_q[0]) begin
                overflow_irq_enable_q <= w_data_q[`TCP_SC_OVERFLOW_IRQ_ENABLE];
                tstop_q <= w_data_q[`TCP_SC_TSTOP];
                ps_q <= w_data_q[2:0];
            end
            if (wr_do && widx == `TCP_IX_MOD) begin
                if (w_strb_q[0])
                    mod_q[7:0] <= w_data_q[7:0];
                if (w_strb_q[1])
                    mod_q[15:8] <= w_data_q[15:8];
            end
            for (i = 0; i < 4; i = i + 1) begin
                // flags at pulse end and capture
                channel_event_flag_q[i] <= cap[i] | cmpe[i] |
                    (channel_event_flag_q[i] &
                     ~(wr_ctl[i] & w_strb_q[0] & ~w_data_q[`TCP_CH_FLAG]));
                if (wr_ctl[i] && w_strb_q[0]) begin
                    channel_irq_enable_q[i] <= w_data_q[`TCP_CH_IE];
                    // link bit only on even channels
                    msb_q[i] <= (i % 2 == 0) ? w_data_q[`TCP_CH_MSB] : 1'b0;
                    msa_q[i] <= w_data_q[`TCP_CH_MSA];
                    edge_level_select_q[2*i +: 2] <=
                        w_data_q[`TCP_CH_ELSB:`TCP_CH_ELSA];
                    toggle_on_overflow_q[i] <= w_data_q[`TCP_CH_TOV];
                    max_duty_bit_q[i] <= w_data_q[`TCP_CH_MAX];
                end
                if (cap[i])
                    val_q[i] <= cnt_q;
                else if (wr_val[i])
                    val_q[i] <= vmerge;
            end
        end
    end

    // buffered pair hand-off, one tracker per pair
    always @(posedge clk) begin
        if (!resetn) begin
            act_q <= 2'h0;
            last_q <= 2'h0;
        end else begin
            for (i = 0; i < 2; i = i + 1) begin
                // pair 2/3 tracked like pair 0/1
                if (!msb_q[2*i]) begin
                    act_q[i] <= 1'b0;
                    last_q[i] <= 1'b0;
                end else begin
                    if (wr_val[2*i+1])
                        last_q[i] <= 1'b1;
                    else if (wr_val[2*i])
                        last_q[i] <= 1'b0;
                    // switch only on the wrap clock
                    if (wrap)
                        act_q[i] <= last_q[i];
                end
            end
        end
    end

    // pin enables and the interrupt request, all registered
    always @(posedge clk) begin
        if (!resetn) begin
            oe_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            for (i = 0; i < 4; i = i + 1)
                oe_q[i] <= ocm[i] & ((edge_level_select_q[2*i +: 2] != `TCP_ELS_OFF) |
                           (max_duty_bit_q[i] & ~toggle_on_overflow_q[i]));
            irq_q <= (overflow_flag_q & overflow_irq_enable_q) |
                     (|(channel_event_flag_q & channel_irq_enable_q));
        end
    end
endmodule // tcp_top

// ==== verif/tcp_top_props.sv ====
// bus handshake checker bound to the timer top
`timescale 1ns/1ps
module tcp_top_props (
    // clock and reset
    input wire clk,
    input wire resetn,
    // write channels
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // read channels
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    // single domain, so one clocking and one reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // take steps of each channel
    sequence s_aw; s_axi_awvalid && s_axi_awready; endsequence
    sequence s_w; s_axi_wvalid && s_axi_wready; endsequence
    sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_b; s_axi_bvalid && s_axi_bready; endsequence
    sequence s_r; s_axi_rvalid && s_axi_rready; endsequence
    property p_aw_drop; s_aw |=> !s_axi_awready; endproperty
    a_aw_drop: assert property (p_aw_drop) else $error("awready stayed up");
    property p_w_drop; s_w |=> !s_axi_wready; endproperty
    a_w_drop: assert property (p_w_drop) else $error("wready stayed up");
    property p_b_lat; s_wr |-> ##[1:2] s_axi_bvalid; endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer late");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
    property p_b_drop; s_b |=> !s_axi_bvalid; endproperty
    a_b_drop: assert property (p_b_drop) else $error("bvalid held after take");
    property p_r_lat; s_ar |=> s_axi_rvalid; endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rdata changed while held");
    property p_r_drop; s_r |=> !s_axi_rvalid; endproperty
    a_r_drop: assert property (p_r_drop) else $error("rvalid held after take");
endmodule // tcp_top_props

bind tcp_top tcp_top_props u_props (.clk, .resetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// ==== verif/test_timer_capture_compare_pwm.sv ====
// self-checking bench for the timer capture/compare/pwm block
`timescale 1ns/1ps
module test_timer_capture_compare_pwm;
    // master side and pin drive
    reg clk = 1'h0, resetn = 1'h0;
    reg awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00;
    reg [31:0] wdata = 32'h0, v, c;
    reg [3:0] pin_in = 4'h0;
    reg [1:0] resp, sel = 2'h0;
    reg last = 1'h0;
    integer hc = 0, hw = 0, pc = 0, pw = 0, mismatches = 0, comparisons = 0;
    wire awready, wready, bvalid, arready, rvalid, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [3:0] pout, poe;
    // wstrb and the external clock pin are tied off
    tcp_top u_dut (.clk(clk), .resetn(resetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ext_clk_pin(1'h0), .irq(irq),
        .chan0_pin_in(pin_in[0]), .chan0_pin_out(pout[0]), .chan0_pin_oe(poe[0]),
        .chan1_pin_in(pin_in[1]), .chan1_pin_out(pout[1]), .chan1_pin_oe(poe[1]),
        .chan2_pin_in(pin_in[2]), .chan2_pin_out(pout[2]), .chan2_pin_oe(poe[2]),
        .chan3_pin_in(pin_in[3]), .chan3_pin_out(pout[3]), .chan3_pin_oe(poe[3]));
    // 40 mhz clock
    initial forever #12.5 clk = ~clk;
    // high time and period of the selected pin, in clocks
    always @(posedge clk) begin
        last <= pout[sel];
        hc <= pout[sel] ? hc + 1 : 0;
        pc <= (pout[sel] && !last) ? 1 : pc + 1;
        if (pout[sel] && !last) pw <= pc;
        if (!pout[sel] && last) hw <= hc;
    end
    task stop_test;
        begin
            if (mismatches == 0 && comparisons > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
            end
        end
    endtask
    // address and data offered together, each dropped once taken
    task wr(input [7:0] a, input [31:0] d);
        begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            @(posedge clk);
            while (!(bvalid && !awvalid && !wvalid)) begin
                if (awready) awvalid <= 1'h0;
                if (wready) wvalid <= 1'h0;
                @(posedge clk);
            end
            // bready a cycle late, so the held response is exercised
            bready <= 1'h1;
            @(posedge clk);
            bready <= 1'h0;
            resp = bresp;
        end
    endtask
    task rd(input [7:0] a, output [31:0] d);
        begin
            araddr <= a;
            arvalid <= 1'h1;
            @(posedge clk);
            while (!rvalid) begin
                if (arready) arvalid <= 1'h0;
                @(posedge clk);
            end
            // rready a cycle late, so held read data is exercised
            rready <= 1'h1;
            @(posedge clk);
            rready <= 1'h0;
            d = rdata;
            resp = rresp;
        end
    endtask
    // wait for a rise (1) or fall (0) of the selected pin
    task ev(input r);
        begin
            @(posedge clk);
            while (!(pout[sel] == r && last != r)) @(posedge clk);
        end
    endtask
    task t_regs;
        begin
            rd(8'h08, v);
            chk(v, 32'hFFFF);
            rd(8'h0C, v);
            chk({30'h0, resp}, 32'h2);
            wr(8'h30, 32'h1);
            chk({30'h0, resp}, 32'h2);
        end
    endtask
    // channel 0 unbuffered pwm, channel 2 linked with 3
    task t_pwm;
        begin
            wr(8'h00, 32'h30);
            wr(8'h08, 32'hFF);
            wr(8'h14, 32'h80);
            wr(8'h10, 32'h1A);
            wr(8'h24, 32'h40);
            wr(8'h20, 32'h2A);
            wr(8'h00, 32'h00);
            ev(0);
            ev(0);
            @(posedge clk);
            chk(hw, 128);
            chk(pw, 256);
            rd(8'h10, v);
            chk(v, 32'h9A);
            // shorten after the compare, lengthen after the overflow
            ev(0);
            wr(8'h14, 32'h40);
            ev(0);
            @(posedge clk);
            chk(hw, 64);
            ev(1);
            wr(8'h14, 32'h80);
            ev(0);
            @(posedge clk);
            chk(hw, 128);
        end
    endtask
    task t_buf;
        begin
            sel <= 2'h2;
            wr(8'h28, 32'h1C);
            ev(0);
            ev(0);
            @(posedge clk);
            chk(hw, 64);
            chk({30'h0, poe[3], poe[2]}, 32'h1);
            ev(1);
            wr(8'h2C, 32'h20);
            ev(0);
            @(posedge clk);
            chk(hw, 64);
            ev(0);
            @(posedge clk);
            chk(hw, 32);
            wr(8'h24, 32'h50);
            ev(0);
            @(posedge clk);
            chk(hw, 80);
        end
    endtask
    // capture with the counter frozen, so the value is known
    task t_cap;
        begin
            rd(8'h00, v);
            chk(v, 32'h80);
            wr(8'h00, 32'hC0);
            repeat (2) @(posedge clk);
            chk({31'h0, irq}, 32'h1);
            wr(8'h00, 32'h20);
            rd(8'h04, c);
            wr(8'h18, 32'h44);
            pin_in <= 4'h2;
            repeat (6) @(posedge clk);
            chk({31'h0, irq}, 32'h1);
            rd(8'h1C, v);
            chk(v, c);
            wr(8'h18, 32'h48);
            pin_in <= 4'h0;
            repeat (6) @(posedge clk);
            rd(8'h18, v);
            chk(v, 32'hC8);
            wr(8'h18, 32'h48);
            repeat (2) @(posedge clk);
            chk({31'h0, irq}, 32'h0);
            pin_in <= 4'h2;
            repeat (6) @(posedge clk);
            rd(8'h18, v);
            chk(v, 32'h48);
        end
    endtask
    task t_duty;
        begin
            wr(8'h00, 32'h00);
            wr(8'h10, 32'h18);
            repeat (300) @(posedge clk);
            chk({31'h0, pout[0]}, 32'h0);
            wr(8'h10, 32'h19);
            repeat (300) @(posedge clk);
            chk({31'h0, pout[0]}, 32'h1);
        end
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        @(posedge clk);
        t_regs;
        t_pwm;
        t_buf;
        t_cap;
        t_duty;
        stop_test;
    end
    // run needs about 4000 clocks; four times that is a hang
    initial begin
        #400000;
        mismatches = mismatches + 1;
        stop_test;
    end
endmodule // test_timer_capture_compare_pwm
